/* rtl/clas_regs.vh */
// clas_regs.vh: register map, field positions and timing counts
// Operation
// R1 - near-limit flag set within two bits of limit
// R2 - near-limit flag drops once clear of limits
// R3 - near-limit flag only valid with attenuator on
// R4 - unlock flag when clocks differ by 0.5%
// R5 - loss flag ORs detectors per line mode
// R6 - drive alarm after 128 empty bit periods
// R7 - drive monitor internal or via monitor pins
// R8 - drive alarm clears when pulses return
// R9 - alarm bits read-only, one while declared
// R10 - transmit control bit layout, reserved bits zero
// R11 - digital loss at 160 empty, clear at 33%
// R12 - rising insert bit gives one PRBS error
// R13 - select zero external pins, one pads
`ifndef CLAS_REGS_VH
`define CLAS_REGS_VH
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define CLAS_ADDR_STATUS 8'h00
`define CLAS_ADDR_TXCTRL 8'h04
`define CLAS_ADDR_CONFIG 8'h08
`define CLAS_ADDR_IRQSTAT 8'h0C
`define CLAS_ADDR_IRQMASK 8'h10
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CLAS_ST_DIG_LOS 5
`define CLAS_ST_ANA_LOS 4
`define CLAS_ST_FIFO 3
`define CLAS_ST_UNLOCK 2
`define CLAS_ST_LOS 1
`define CLAS_ST_DRIVE 0
`define CLAS_TC_INT_MON 5
`define CLAS_TC_PRBS_ERR 4
`define CLAS_TC_ALL_ONES 2
`define CLAS_TC_CLK_INV 1
`define CLAS_TC_LEVEL 0
`define CLAS_TC_MASK 8'h37
`define CLAS_CF_JA_EN 0
`define CLAS_CF_JA_DEEP 1
`define CLAS_CF_MODE_LO 2
`define CLAS_CF_MODE_HI 3
`define CLAS_MODE_E3 2'h0
`define CLAS_CF_MASK 8'h0F
// ----------------------------------------------------------------
// reset values and timing counts (in bit periods)
// ----------------------------------------------------------------
`define CLAS_TC_RESET 8'h00
`define CLAS_CF_RESET 8'h00
`define CLAS_NEAR_BITS 6'h02
`define CLAS_DEPTH_SMALL 6'h10
`define CLAS_DEPTH_LARGE 6'h20
`define CLAS_DRIVE_LIMIT 8'h80
`define CLAS_DLOS_LIMIT 8'hA0
`define CLAS_DENS_WIN_LAST 5'h1F
`define CLAS_DENS_MIN 6'h0B
`define CLAS_LOCK_WIN 11'h3E8
`define CLAS_LOCK_TOL 11'h005
`endif

/* rtl/clas_pulse_watch.v */
// clas_pulse_watch.v: pulse absence detector on a bit-period strobe
`timescale 1ns/100ps
`include "clas_regs.vh"
module clas_pulse_watch #(
    parameter [7:0] LIMIT = 8'h80,
    parameter DENSITY = 0
) (
    input wire clk,
    input wire nrst,
    input wire bit_tick,
    input wire pulse,
    output reg alarm
);
    reg [7:0] run;
    reg [4:0] win;
    reg [5:0] hits;
    wire win_end;
    wire [5:0] hits_now;
    wire clear_ok;

    // density window: count pulses in 32 bit periods
    assign win_end = (win == `CLAS_DENS_WIN_LAST);
    assign hits_now = hits + {5'h00, pulse};
    assign clear_ok = (DENSITY != 0) ?
        (win_end && hits_now >= `CLAS_DENS_MIN) : pulse;

    // run of empty bit periods, declare at the limit, clear on pulses
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            run <= 8'h00;
            win <= 5'h00;
            hits <= 6'h00;
            alarm <= 1'b0;
        end else if (bit_tick) begin
            if (pulse)
                run <= 8'h00;
            else if (run != LIMIT)
                run <= run + 8'h01;
            win <= win + 5'h01;
            hits <= win_end ? 6'h00 : hits_now;
            if (!pulse && run == LIMIT - 8'h01)
                alarm <= 1'b1; // R6 R11
            else if (alarm && clear_ok)
                alarm <= 1'b0; // R8 R11
        end
    end
endmodule // clas_pulse_watch

/* rtl/clas_lock_check.v */
// clas_lock_check.v: recovered clock against reference frequency check
`timescale 1ns/100ps
`include "clas_regs.vh"
module clas_lock_check (
    input wire clk,
    input wire nrst,
    input wire ref_edge,
    input wire rec_edge,
    output reg unlocked
);
    reg [10:0] ref_cnt;
    reg [10:0] rec_cnt;
    wire [10:0] rec_total;
    wire win_end;

    // count recovered edges over a window of reference edges
    assign rec_total = rec_cnt + {10'h000, rec_edge};
    assign win_end = ref_edge && (ref_cnt == `CLAS_LOCK_WIN - 11'h001);

    // at window end compare against nominal, tolerance 0.5 percent
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ref_cnt <= 11'h000;
            rec_cnt <= 11'h000;
            unlocked <= 1'b0;
        end else if (win_end) begin
            ref_cnt <= 11'h000;
            rec_cnt <= 11'h000;
            unlocked <= // R4
                (rec_total <= `CLAS_LOCK_WIN - `CLAS_LOCK_TOL) ||
                (rec_total >= `CLAS_LOCK_WIN + `CLAS_LOCK_TOL);
        end else begin
            if (ref_edge)
                ref_cnt <= ref_cnt + 11'h001;
            if (rec_edge && rec_cnt != 11'h7FF)
                rec_cnt <= rec_total;
        end
    end
endmodule // clas_lock_check

/* rtl/clas_top.v */
// clas_top.v: per-channel line alarm status and transmit control
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "clas_regs.vh"
module clas_top (
    input wire MCLK,
    input wire NRST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    output reg IRQ,
    input wire BIT_TICK,
    input wire RX_POS,
    input wire RX_NEG,
    input wire ANALOG_LOS,
    input wire G775_LOS,
    input wire REC_CLK,
    input wire REF_CLK,
    input wire [5:0] JA_FILL,
    input wire TX_OUT_POS,
    input wire TX_OUT_NEG,
    input wire MONITOR_IN_POS,
    input wire MONITOR_IN_NEG,
    output reg SEND_ALL_ONES,
    output reg TX_CLOCK_INVERT,
    output reg TX_LINE_LEVEL,
    output reg PRBS_ERR_INSERT,
    output reg JA_ENABLE
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    localparam NPIN = 8;
    localparam P_RXP = 0;
    localparam P_RXN = 1;
    localparam P_ALOS = 2;
    localparam P_GLOS = 3;
    localparam P_REC = 4;
    localparam P_REF = 5;
    localparam P_MONP = 6;
    localparam P_MONN = 7;

    wire [NPIN-1:0] pin_raw;
    reg [NPIN-1:0] sync1;
    reg [NPIN-1:0] sync2;
    reg [NPIN-1:0] sync3;
    reg [NPIN-1:0] pin;
    reg [NPIN-1:0] pin_d;

    assign pin_raw = {MONITOR_IN_NEG, MONITOR_IN_POS, REF_CLK, REC_CLK,
                      G775_LOS, ANALOG_LOS, RX_NEG, RX_POS};

    // three stages per pin; level moves only when stages two and three agree
    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1) begin : pin_sync
            always @(posedge MCLK or negedge NRST) begin
                if (!NRST) begin
                    sync1[g] <= 1'b0;
                    sync2[g] <= 1'b0;
                    sync3[g] <= 1'b0;
                    pin[g] <= 1'b0;
                    pin_d[g] <= 1'b0;
                end else begin
                    sync1[g] <= pin_raw[g];
                    sync2[g] <= sync1[g];
                    sync3[g] <= sync2[g];
                    if (sync2[g] == sync3[g])
                        pin[g] <= sync3[g];
                    pin_d[g] <= pin[g];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // configuration and transmit control registers
    // ----------------------------------------------------------------
    reg [7:0] tx_ctrl;
    reg [7:0] config_reg;
    reg [5:0] irq_mask;
    reg [5:0] irq_stat;
    wire wr_en;
    wire rd_setup;
    wire addr_hit;
    wire [7:0] wr_byte;
    wire [7:0] next_tx_ctrl;

    // register writes take effect at the access edge, zero wait states
    assign wr_en = PSEL && PENABLE && PWRITE && addr_hit;
    assign rd_setup = PSEL && !PENABLE;
    assign wr_byte = PWDATA[7:0];
    assign next_tx_ctrl = wr_byte & `CLAS_TC_MASK; // R10

    // address decode, the status register ignores writes
    assign addr_hit = (PADDR == `CLAS_ADDR_STATUS) ||
                      (PADDR == `CLAS_ADDR_TXCTRL) ||
                      (PADDR == `CLAS_ADDR_CONFIG) ||
                      (PADDR == `CLAS_ADDR_IRQSTAT) ||
                      (PADDR == `CLAS_ADDR_IRQMASK);
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_hit;

    // transmit control, reserved bits 7, 6 and 3 hold zero
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            tx_ctrl <= `CLAS_TC_RESET;
            PRBS_ERR_INSERT <= 1'b0;
        end else begin
            PRBS_ERR_INSERT <= 1'b0;
            if (wr_en && PADDR == `CLAS_ADDR_TXCTRL) begin
                tx_ctrl <= next_tx_ctrl; // R10
                // single error only on a rising insert bit
                if (next_tx_ctrl[`CLAS_TC_PRBS_ERR] &&
                    !tx_ctrl[`CLAS_TC_PRBS_ERR])
                    PRBS_ERR_INSERT <= 1'b1; // R12
            end
        end
    end

    // channel configuration and interrupt mask
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            config_reg <= `CLAS_CF_RESET;
            irq_mask <= 6'h00;
        end else if (wr_en) begin
            if (PADDR == `CLAS_ADDR_CONFIG)
                config_reg <= wr_byte & `CLAS_CF_MASK;
            if (PADDR == `CLAS_ADDR_IRQMASK)
                irq_mask <= wr_byte[5:0];
        end
    end

    // control outputs registered from the register bits, one cycle later
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            SEND_ALL_ONES <= 1'b0;
            TX_CLOCK_INVERT <= 1'b0;
            TX_LINE_LEVEL <= 1'b0;
            JA_ENABLE <= 1'b0;
        end else begin
            SEND_ALL_ONES <= tx_ctrl[`CLAS_TC_ALL_ONES];
            TX_CLOCK_INVERT <= tx_ctrl[`CLAS_TC_CLK_INV];
            TX_LINE_LEVEL <= tx_ctrl[`CLAS_TC_LEVEL];
            JA_ENABLE <= config_reg[`CLAS_CF_JA_EN];
        end
    end

    // ----------------------------------------------------------------
    // jitter attenuator fifo near-limit alarm
    // ----------------------------------------------------------------
    wire [5:0] ja_depth;
    wire fifo_near_raw;
    reg fifo_near_limit;

    assign ja_depth = config_reg[`CLAS_CF_JA_DEEP] ?
                      `CLAS_DEPTH_LARGE : `CLAS_DEPTH_SMALL;
    // near either end: two bits from empty or from full
    assign fifo_near_raw = (JA_FILL <= `CLAS_NEAR_BITS) ||
                           (JA_FILL >= ja_depth - `CLAS_NEAR_BITS);

    // follows the fill level both ways, held low with attenuator off
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST)
            fifo_near_limit <= 1'b0;
        else
            fifo_near_limit <= config_reg[`CLAS_CF_JA_EN] && // R3
                               fifo_near_raw; // R1 R2
    end

    // ----------------------------------------------------------------
    // receive loss of lock
    // ----------------------------------------------------------------
    wire rec_edge;
    wire ref_edge;
    wire recovered_clock_unlocked;

    assign rec_edge = pin[P_REC] && !pin_d[P_REC];
    assign ref_edge = pin[P_REF] && !pin_d[P_REF];

    // frequency comparison over a window of reference edges
    clas_lock_check u_lock (
        .clk(MCLK),
        .nrst(NRST),
        .ref_edge(ref_edge),
        .rec_edge(rec_edge),
        .unlocked(recovered_clock_unlocked)
    );

    // ----------------------------------------------------------------
    // receive loss of signal
    // ----------------------------------------------------------------
    wire rx_pulse;
    wire digital_los;
    wire line_e3;
    reg signal_missing;

    assign rx_pulse = pin[P_RXP] || pin[P_RXN];
    assign line_e3 = (config_reg[`CLAS_CF_MODE_HI:`CLAS_CF_MODE_LO] ==
                      `CLAS_MODE_E3);

    // digital detector: 160 empty bits declare, density clears
    clas_pulse_watch #(
        .LIMIT(`CLAS_DLOS_LIMIT),
        .DENSITY(1)
    ) u_dlos (
        .clk(MCLK),
        .nrst(NRST),
        .bit_tick(BIT_TICK),
        .pulse(rx_pulse),
        .alarm(digital_los)
    );

    // combined loss flag chosen by line mode
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST)
            signal_missing <= 1'b0;
        else if (line_e3)
            signal_missing <= pin[P_GLOS]; // R5
        else
            signal_missing <= digital_los || pin[P_ALOS]; // R5
    end

    // ----------------------------------------------------------------
    // transmit drive monitor
    // ----------------------------------------------------------------
    wire mon_pulse;
    wire transmit_pulse_absent;

    // internal select watches the pads, otherwise the monitor pins
    assign mon_pulse = tx_ctrl[`CLAS_TC_INT_MON] ? // R7 R13
                       (TX_OUT_POS || TX_OUT_NEG) :
                       (pin[P_MONP] || pin[P_MONN]);

    // 128 empty bit periods declare, first pulse clears
    clas_pulse_watch #(
        .LIMIT(`CLAS_DRIVE_LIMIT),
        .DENSITY(0)
    ) u_drive (
        .clk(MCLK),
        .nrst(NRST),
        .bit_tick(BIT_TICK),
        .pulse(mon_pulse),
        .alarm(transmit_pulse_absent)
    );

    // ----------------------------------------------------------------
    // alarm status and interrupts
    // ----------------------------------------------------------------
    wire [5:0] status;
    reg [5:0] status_d;
    wire [5:0] alarm_rise;
    wire [5:0] irq_clear;
    wire [5:0] next_irq_stat;

    // live alarm levels, one while declared
    assign status = {digital_los, pin[P_ALOS], fifo_near_limit, // R9
                     recovered_clock_unlocked, signal_missing,
                     transmit_pulse_absent};
    assign alarm_rise = status & ~status_d;
    assign irq_clear = (wr_en && PADDR == `CLAS_ADDR_IRQSTAT) ?
                       wr_byte[5:0] : 6'h00;
    // a new declaration wins over a clear in the same cycle
    assign next_irq_stat = (irq_stat & ~irq_clear) | alarm_rise;

    // sticky bits for each declaration, level interrupt from mask
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            status_d <= 6'h00;
            irq_stat <= 6'h00;
            IRQ <= 1'b0;
        end else begin
            status_d <= status;
            irq_stat <= next_irq_stat;
            IRQ <= |(next_irq_stat & irq_mask);
        end
    end

    // ----------------------------------------------------------------
    // read data, captured in the setup cycle
    // ----------------------------------------------------------------
    reg [7:0] rd_byte;

    // read mux, unmapped addresses read zero
    always @* begin
        rd_byte = 8'h00;
        case (PADDR)
            `CLAS_ADDR_STATUS: rd_byte = {2'h0, status}; // R9
            `CLAS_ADDR_TXCTRL: rd_byte = tx_ctrl; // R10
            `CLAS_ADDR_CONFIG: rd_byte = config_reg;
            `CLAS_ADDR_IRQSTAT: rd_byte = {2'h0, irq_stat};
            `CLAS_ADDR_IRQMASK: rd_byte = {2'h0, irq_mask};
            default: rd_byte = 8'h00;
        endcase
    end

    // read data register, stands through the access phase
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST)
            PRDATA <= 32'h0000_0000;
        else if (rd_setup && !PWRITE)
            PRDATA <= {24'h00_0000, rd_byte};
    end
endmodule // clas_top

/* verification/clas_props.sv */
// clas_props.sv: port assertions for the channel alarm block
`timescale 1ns/100ps
`include "clas_regs.vh"
module clas_props (
    input logic MCLK,
    input logic NRST,
    input logic PSEL,
    input logic PENABLE,
    input logic PWRITE,
    input logic [7:0] PADDR,
    input logic [31:0] PWDATA,
    input logic [31:0] PRDATA,
    input logic PREADY,
    input logic PSLVERR,
    input logic IRQ,
    input logic SEND_ALL_ONES,
    input logic TX_CLOCK_INVERT,
    input logic TX_LINE_LEVEL,
    input logic PRBS_ERR_INSERT,
    input logic JA_ENABLE
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);
    wire wr = PSEL && PENABLE && PWRITE;
    wire mapped = PADDR <= 8'h10 && PADDR[1:0] == 2'h0;
    wire tx4 = wr && PADDR == `CLAS_ADDR_TXCTRL && PWDATA[4];
    reg [5:0] msk;
    // ------------------------------------------------------------
    // mask as last written by software
    // ------------------------------------------------------------
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            msk <= 6'h00;
        end else if (wr && PADDR == `CLAS_ADDR_IRQMASK) begin
            msk <= PWDATA[5:0];
        end
    end
    a_ready_high: assert property (PREADY) else $error("pready low");
    a_err_map: assert property (PSEL && PENABLE |-> PSLVERR == !mapped)
        else $error("slverr wrong");
    a_err_setup: assert property (!PENABLE |-> !PSLVERR)
        else $error("slverr early");
    a_rdata_top: assert property (PENABLE |-> PRDATA[31:8] == 24'h00_0000)
        else $error("read upper bits");
    a_tx_follow: assert property (wr && PADDR == `CLAS_ADDR_TXCTRL |=> ##1
        {SEND_ALL_ONES, TX_CLOCK_INVERT, TX_LINE_LEVEL} == $past(PWDATA[2:0], 2))
        else $error("tx pins wrong");
    a_ja_follow: assert property (wr && PADDR == `CLAS_ADDR_CONFIG |=> ##1
        JA_ENABLE == $past(PWDATA[0], 2)) else $error("ja enable wrong");
    a_prbs_single: assert property (PRBS_ERR_INSERT |=> !PRBS_ERR_INSERT)
        else $error("insert too long");
    a_prbs_cause: assert property (PRBS_ERR_INSERT |->
        $past(tx4, 1) || $past(tx4, 2)) else $error("insert uncaused");
    a_irq_masked: assert property (msk == 6'h00 && $past(msk) == 6'h00 |-> !IRQ)
        else $error("irq while masked");
    c_insert: cover property (PRBS_ERR_INSERT);
    c_slverr: cover property (PENABLE && PSLVERR);
    c_irq: cover property ($rose(IRQ));
endmodule // clas_props

bind clas_top clas_props u_props (.MCLK(MCLK), .NRST(NRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ),
    .SEND_ALL_ONES(SEND_ALL_ONES), .TX_CLOCK_INVERT(TX_CLOCK_INVERT),
    .TX_LINE_LEVEL(TX_LINE_LEVEL), .PRBS_ERR_INSERT(PRBS_ERR_INSERT),
    .JA_ENABLE(JA_ENABLE));

/* verification/clas_host.sv */
// clas_host.sv: host processor model issuing apb transfers
`timescale 1ns/100ps
module clas_host (
    input logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr
);
    logic [31:0] rdata;
    logic err;
    // ------------------------------------------------------------
    // idle bus at time zero
    // ------------------------------------------------------------
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    // one transfer: setup, access until pready, then release
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a; // released lines do not keep old value
        pwdata <= ~d;
        @(posedge clk);
    endtask
endmodule // clas_host

/* verification/testbench.sv */
// testbench.sv: self-checking bench for the channel alarm block
`timescale 1ns/100ps
`include "clas_regs.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    n_fail++; $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
    logic MCLK = 1'b0;
    logic NRST = 1'b0;
    logic BIT_TICK = 1'b0;
    logic analog_los = 1'b0;
    logic g775_los = 1'b0;
    logic ref_clk = 1'b0;
    logic rec_clk = 1'b0;
    logic [5:0] fill = 6'h00;
    logic [5:0] pins = 6'h00;
    logic psel, penable, pwrite, pready, pslverr, irq, ja_en;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] txo;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    int n_ins = 0;
    int rec_half = 4;
    integer seed = 32'h0000_8a02;
    clas_top u_clas_top (.MCLK(MCLK), .NRST(NRST), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
        .BIT_TICK(BIT_TICK), .RX_POS(pins[5]), .RX_NEG(pins[4]),
        .ANALOG_LOS(analog_los), .G775_LOS(g775_los), .REC_CLK(rec_clk),
        .REF_CLK(ref_clk), .JA_FILL(fill), .TX_OUT_POS(pins[1]),
        .TX_OUT_NEG(pins[0]), .MONITOR_IN_POS(pins[3]),
        .MONITOR_IN_NEG(pins[2]), .SEND_ALL_ONES(txo[2]),
        .TX_CLOCK_INVERT(txo[1]), .TX_LINE_LEVEL(txo[0]),
        .PRBS_ERR_INSERT(txo[3]), .JA_ENABLE(ja_en));
    clas_host u_clas_host (.clk(MCLK), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    // ------------------------------------------------------------
    // clocks, insert counter and hang limit
    // ------------------------------------------------------------
    always #5 MCLK = ~MCLK;
    always begin
        repeat (4) @(posedge MCLK);
        ref_clk <= ~ref_clk;
    end
    always begin
        repeat (rec_half) @(posedge MCLK);
        rec_clk <= ~rec_clk;
    end
    always @(posedge MCLK) begin
        cyc++;
        if (txo[3] === 1'b1) n_ins++;
        if (cyc == 60000) begin
            n_fail++;
            end_sim();
        end
    end
    // expected near-limit flag from fill, enable and depth
    function automatic logic near(input logic [5:0] f, input logic [1:0] c);
        near = c[0] & (f <= `CLAS_NEAR_BITS || f >= (c[1] ?
            `CLAS_DEPTH_LARGE : `CLAS_DEPTH_SMALL) - `CLAS_NEAR_BITS);
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_clas_host.xfer(1'b1, a, d);
    endtask
    task automatic stchk(input int b, input logic e);
        u_clas_host.xfer(1'b0, `CLAS_ADDR_STATUS, 32'h0000_0000);
        `CHK("status bit", e, u_clas_host.rdata[b])
    endtask
    // bit periods; s picks which line pairs carry bipolar pulses
    task automatic ticks(input int n, input logic [2:0] s);
        for (int i = 0; i < n; i++) begin
            pins <= {s[2], s[2], s[1], s[1], s[0], s[0]} & {3{~i[0], i[0]}};
            repeat (5) @(posedge MCLK);
            BIT_TICK <= 1'b1;
            @(posedge MCLK);
            BIT_TICK <= 1'b0;
            repeat (2) @(posedge MCLK);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        logic [31:0] d;
        logic [7:0] tx;
        logic [1:0] cfg;
        logic [5:0] f;
        logic [5:0] corner [8];
        int exp_ins;
        corner = '{6'h02, 6'h03, 6'h0D, 6'h0E, 6'h02, 6'h03, 6'h1D, 6'h1E};
        repeat (20) @(posedge MCLK);
        NRST <= 1'b1;
        @(posedge MCLK);
        u_clas_host.xfer(1'b0, 8'h14, 32'h0000_0000);
        `CHK("unmapped err", 1'b1, u_clas_host.err)
        wr(`CLAS_ADDR_STATUS, 32'h0000_00FF);
        stchk(`CLAS_ST_DRIVE, 1'b0);
        tx = 8'h00;
        exp_ins = 0;
        for (int k = 0; k < 10; k++) begin
            d = (k < 2) ? 32'h0000_0010 : $random(seed);
            exp_ins += (~tx[4] & d[4]);
            tx = d[7:0];
            wr(`CLAS_ADDR_TXCTRL, d);
            u_clas_host.xfer(1'b0, `CLAS_ADDR_TXCTRL, 32'h0000_0000);
            `CHK("txctrl", {24'h00_0000, tx & 8'h37}, u_clas_host.rdata)
            `CHK("tx pins", tx[2:0], txo[2:0])
        end
        `CHK("inserts", exp_ins, n_ins)
        wr(`CLAS_ADDR_CONFIG, 32'h0000_0005);
        wr(`CLAS_ADDR_TXCTRL, 32'h0000_0020);
        ticks(1, 3'b001);
        ticks(127, 3'b000);
        stchk(`CLAS_ST_DRIVE, 1'b0);
        ticks(1, 3'b000);
        stchk(`CLAS_ST_DRIVE, 1'b1);
        ticks(30, 3'b000);
        stchk(`CLAS_ST_DIG_LOS, 1'b0);
        stchk(`CLAS_ST_LOS, 1'b0);
        ticks(1, 3'b000);
        stchk(`CLAS_ST_DIG_LOS, 1'b1);
        stchk(`CLAS_ST_LOS, 1'b1);
        `CHK("irq masked", 1'b0, irq)
        wr(`CLAS_ADDR_TXCTRL, 32'h0000_0000);
        ticks(1, 3'b010);
        stchk(`CLAS_ST_DRIVE, 1'b0);
        ticks(128, 3'b001);
        stchk(`CLAS_ST_DRIVE, 1'b1);
        wr(`CLAS_ADDR_TXCTRL, 32'h0000_0020);
        ticks(1, 3'b001);
        stchk(`CLAS_ST_DRIVE, 1'b0);
        ticks(64, 3'b100);
        stchk(`CLAS_ST_DIG_LOS, 1'b0);
        analog_los <= 1'b1;
        repeat (6) @(posedge MCLK);
        stchk(`CLAS_ST_LOS, 1'b1);
        wr(`CLAS_ADDR_CONFIG, 32'h0000_0001);
        stchk(`CLAS_ST_LOS, 1'b0);
        g775_los <= 1'b1;
        repeat (6) @(posedge MCLK);
        stchk(`CLAS_ST_LOS, 1'b1);
        analog_los <= 1'b0;
        g775_los <= 1'b0;
        wr(`CLAS_ADDR_IRQMASK, 32'h0000_003F);
        repeat (2) @(posedge MCLK);
        `CHK("irq set", 1'b1, irq)
        wr(`CLAS_ADDR_IRQSTAT, 32'h0000_003F);
        repeat (3) @(posedge MCLK);
        `CHK("irq clear", 1'b0, irq)
        for (int k = 0; k < 16; k++) begin
            cfg = (k < 4) ? 2'h1 : (k < 8) ? 2'h3 : 2'($random(seed));
            f = (k < 8) ? corner[k] : 6'($random(seed));
            fill <= f;
            wr(`CLAS_ADDR_CONFIG, {30'h0000_0000, cfg});
            stchk(`CLAS_ST_FIFO, near(f, cfg));
        end
        repeat (17000) @(posedge MCLK);
        stchk(`CLAS_ST_UNLOCK, 1'b0);
        rec_half = 5;
        repeat (17000) @(posedge MCLK);
        stchk(`CLAS_ST_UNLOCK, 1'b1);
        end_sim();
    end
endmodule // testbench
